// File: dv/uda_host_model.sv
// usb host model: sends tokens and bus events toward both engines
`timescale 1ns/1ps
`default_nettype none
module uda_host_model
(
  input  wire logic       i_core_clk,
  output logic [1:0]      o_pkt_valid,
  output logic [1:0][6:0] o_pkt_addr,
  output logic [1:0]      o_sof_eop,
  output logic [1:0]      o_bus_reset
);
  initial
  begin
    o_pkt_valid = '0;
    o_pkt_addr  = '1;
    o_sof_eop   = '0;
    o_bus_reset = '0;
  end
  // idle address lines show the inverse, so a stale match cannot hide
  task token(input int e, input logic [6:0] a);
    @(posedge i_core_clk);
    o_pkt_valid[e] <= 1'b1;
    o_pkt_addr[e]  <= a;
    @(posedge i_core_clk);
    o_pkt_valid[e] <= 1'b0;
    o_pkt_addr[e]  <= ~a;
  endtask : token
  task automatic events(input logic [1:0] sof, input logic [1:0] rst);
    @(posedge i_core_clk);
    o_sof_eop   <= sof;
    o_bus_reset <= rst;
    @(posedge i_core_clk);
    o_sof_eop   <= '0;
    o_bus_reset <= '0;
  endtask : events
endmodule : uda_host_model
`default_nettype wire

// File: dv/usb_device_address_and_status_test.sv
// self-checking bench for the address filter and status registers
`timescale 1ns/1ps
`default_nettype none
module usb_device_address_and_status_test;
  import uda_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic cpu_wr = 0, cpu_rd = 0, hpi_wr = 0, hpi_rd = 0, vbus = 0, id = 0;
  logic [15:0] cpu_addr = '0, cpu_wdata = '0, hpi_addr = '0, hpi_wdata = '0;
  logic [15:0] cpu_rdata, hpi_rdata;
  logic [1:0] pkt_valid, pkt_accept, sof_eop, bus_reset, rd_pend, pk_pend;
  logic [1:0][6:0] pkt_addr;
  logic [1:0][7:0] ep_done = '0, ep_nak = '0, nak_en = '0;
  logic [15:0] rd_q[$];
  logic [1:0] acc_q[$];
  logic [6:0] a;
  int fails = 0, total_checks = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  uda_host_model host_u (.i_core_clk(core_clk), .o_pkt_valid(pkt_valid),
    .o_pkt_addr(pkt_addr), .o_sof_eop(sof_eop), .o_bus_reset(bus_reset));
  uda_regs dut_u (.i_core_clk(core_clk), .i_rstn(rst_n), .i_clk_en(clk_en),
    .i_cpu_addr(cpu_addr), .i_cpu_wr(cpu_wr), .i_cpu_rd(cpu_rd),
    .i_cpu_wdata(cpu_wdata), .o_cpu_rdata(cpu_rdata),
    .i_hpi_addr(hpi_addr), .i_hpi_wr(hpi_wr), .i_hpi_rd(hpi_rd),
    .i_hpi_wdata(hpi_wdata), .o_hpi_rdata(hpi_rdata),
    .i_pkt_valid(pkt_valid), .i_pkt_addr(pkt_addr),
    .o_pkt_accept(pkt_accept), .i_ep_done(ep_done), .i_ep_nak(ep_nak),
    .i_nak_int_en(nak_en), .i_sof_eop(sof_eop), .i_bus_reset(bus_reset),
    .i_vbus_valid(vbus), .i_otg_id(id));
  task automatic close_out();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // cpu and hpi never read in one cycle, so one queue keeps order
  always @(posedge core_clk)
  begin
    rd_pend <= {hpi_rd, cpu_rd};
    pk_pend <= pkt_valid;
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out();
    end
  end
  always @(negedge core_clk)
  begin
    if (rd_pend[0]) chk(cpu_rdata, rd_q.pop_front());
    if (rd_pend[1]) chk(hpi_rdata, rd_q.pop_front());
    if (|pk_pend) chk({14'h0, pkt_accept}, {14'h0, acc_q.pop_front()});
  end
  task automatic bus(input bit p, input bit w, input logic [15:0] ad, d);
    @(posedge core_clk);
    if (p)
    begin
      hpi_wr <= w; hpi_rd <= !w; hpi_addr <= ad; hpi_wdata <= d;
    end
    else
    begin
      cpu_wr <= w; cpu_rd <= !w; cpu_addr <= ad; cpu_wdata <= d;
    end
    @(posedge core_clk);
    {cpu_wr, cpu_rd, hpi_wr, hpi_rd} <= 4'h0;
  endtask : bus
  task automatic wr(input bit p, input logic [15:0] ad, d);
    bus(p, 1'b1, ad, d);
  endtask : wr
  task automatic rd(input bit p, input logic [15:0] ad, e);
    rd_q.push_back(e);
    bus(p, 1'b0, ad, 16'h0000);
  endtask : rd
  task automatic tok(input int e, input logic [6:0] ta, input logic m);
    acc_q.push_back(2'(m) << e);
    host_u.token(e, ta);
  endtask : tok
  initial
  begin
    void'($urandom(32'h76d2));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(0, OFS_STAT_1, RST_STATUS);
    rd(1, OFS_ADDR_1, 16'h0000);
    tok(0, 7'h00, 1'b1);
    a = 7'($urandom_range(1, 127));
    wr(0, OFS_ADDR_1, {9'h0, a});
    tok(0, a, 1'b1);
    tok(0, a ^ 7'h01, 1'b0);
    tok(1, a, 1'b0);
    wr(1, OFS_ADDR_2, {9'h0, a});
    tok(1, a, 1'b1);
    wr(0, OFS_INTEN_1, MASK_ENG_1);
    wr(1, OFS_INTEN_2, MASK_ENG_2);
    rd(1, OFS_INTEN_2, MASK_ENG_2);
    host_u.events(2'b11, 2'b11);
    ep_done <= '1; vbus <= 1'b1; id <= 1'b1;
    @(posedge core_clk);
    ep_done <= '0;
    rd(0, OFS_STAT_1, 16'hc3ff);
    rd(1, OFS_STAT_2, 16'h03ff);
    wr(1, OFS_STAT_1, 16'h8001);
    wr(0, OFS_STAT_1, 16'h0000);
    rd(1, OFS_STAT_1, 16'h43fe);
    vbus <= 1'b0;
    rd(0, OFS_STAT_1, 16'hc3fe);
    wr(0, OFS_STAT_1, MASK_ENG_1);
    wr(0, OFS_STAT_2, MASK_ENG_2);
    ep_nak[0][3] <= 1'b1;
    @(posedge core_clk);
    ep_nak <= '0;
    rd(0, OFS_STAT_1, 16'h0000);
    nak_en[0][3] <= 1'b1; ep_nak[0][3] <= 1'b1;
    @(posedge core_clk);
    ep_nak <= '0;
    rd(0, OFS_STAT_1, 16'h0008);
    // bus reset and endpoint event land in the clearing cycle
    fork
      host_u.events(2'b00, 2'b01);
      begin
        @(posedge core_clk);
        ep_done[0][2] <= 1'b1; cpu_wr <= 1'b1;
        cpu_addr <= OFS_STAT_1; cpu_wdata <= 16'h010c;
        @(posedge core_clk);
        ep_done <= '0; cpu_wr <= 1'b0;
      end
    join
    rd(0, OFS_STAT_1, 16'h0104);
    wr(0, OFS_STAT_1, 16'h0100);
    // a frozen cycle must drop the endpoint pulse
    clk_en <= 1'b0; ep_done[0][5] <= 1'b1;
    @(posedge core_clk);
    clk_en <= 1'b1; ep_done <= '0;
    wr(0, OFS_INTEN_1, 16'h0000);
    host_u.events(2'b01, 2'b01);
    rd(0, OFS_STAT_1, 16'h0004);
    rd(1, 16'hc0a0, 16'h0000);
    repeat (3) @(posedge core_clk);
    // mid-run reset must bring the address back to zero
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    tok(0, a, 1'b0);
    tok(0, 7'h00, 1'b1);
    repeat (3) @(posedge core_clk);
    close_out();
  end
endmodule : usb_device_address_and_status_test
`default_nettype wire

// File: include/uda_pkg.sv
// constants shared by the usb device address and status register bank
package uda_pkg;
  localparam int unsigned   ENG_COUNT      = 2;
  localparam int unsigned   ADDR_W         = 16;
  localparam int unsigned   DATA_W         = 16;
  localparam int unsigned   DEV_ADDR_W     = 7;
  localparam int unsigned   EP_COUNT       = 8;
  // register offsets, engine one then engine two
  localparam logic [15:0]   OFS_INTEN_1    = 16'hc08c;
  localparam logic [15:0]   OFS_ADDR_1     = 16'hc08e;
  localparam logic [15:0]   OFS_STAT_1     = 16'hc090;
  localparam logic [15:0]   OFS_INTEN_2    = 16'hc0ac;
  localparam logic [15:0]   OFS_ADDR_2     = 16'hc0ae;
  localparam logic [15:0]   OFS_STAT_2     = 16'hc0b0;
  // status and enable field positions
  localparam int unsigned   BIT_VBUS       = 15;
  localparam int unsigned   BIT_ID         = 14;
  localparam int unsigned   BIT_SOF_EOP    = 9;
  localparam int unsigned   BIT_BUS_RESET  = 8;
  // implemented bits per engine; the rest are reserved and read zero
  localparam logic [15:0]   MASK_ENG_1     = 16'hc3ff;
  localparam logic [15:0]   MASK_ENG_2     = 16'h03ff;
  // values after reset
  localparam logic [6:0]    RST_DEV_ADDR   = 7'h00;
  localparam logic [15:0]   RST_STATUS     = 16'h0000;
  localparam logic [15:0]   RST_INTEN      = 16'h0000;

  typedef enum logic [1:0] {
    RS_NONE  = 2'b00,
    RS_ADDR  = 2'b01,
    RS_STAT  = 2'b11,
    RS_INTEN = 2'b10
  } uda_rsel_type;
endpackage : uda_pkg

// File: src/uda_regs.sv
// address filter and event status registers of both device engines
// Operation
// - the bus address is bits 6:0; bit 7 and the upper byte are reserved.
// - reset loads the address field with the default address zero.
// - only traffic to the stored address is answered, the rest ignored.
// - writing one to a status flag clears it, writing zero leaves it alone.
// - status is reachable from the parallel host port and the processor.
// - bit 15 sets on each supply threshold crossing, engine one only.
// - supply and id flags exist in engine one only; reserved in engine two.
// - bit 14 sets on each rising and falling edge of the id pin.
// - bit 9 sets when a start-of-frame or end-of-packet marker is received.
// - bit 8 sets when a host bus reset is detected.
// - bits 7:0 set on transaction-done of endpoint_zero to endpoint_seven.
// - with an endpoint's nak enable set, a nak answer also sets its flag.
// - an enable register gates each status event at the same bit position.
`timescale 1ns/1ps
`default_nettype none
module uda_regs
  import uda_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_clk_en,
  input  wire logic [15:0]            i_cpu_addr,
  input  wire logic                   i_cpu_wr,
  input  wire logic                   i_cpu_rd,
  input  wire logic [15:0]            i_cpu_wdata,
  output logic      [15:0]            o_cpu_rdata,
  input  wire logic [15:0]            i_hpi_addr,
  input  wire logic                   i_hpi_wr,
  input  wire logic                   i_hpi_rd,
  input  wire logic [15:0]            i_hpi_wdata,
  output logic      [15:0]            o_hpi_rdata,
  input  wire logic [1:0]             i_pkt_valid,
  input  wire logic [1:0][6:0]        i_pkt_addr,
  output logic      [1:0]             o_pkt_accept,
  input  wire logic [1:0][7:0]        i_ep_done,
  input  wire logic [1:0][7:0]        i_ep_nak,
  input  wire logic [1:0][7:0]        i_nak_int_en,
  input  wire logic [1:0]             i_sof_eop,
  input  wire logic [1:0]             i_bus_reset,
  input  wire logic                   i_vbus_valid,
  input  wire logic                   i_otg_id
);
  import uda_pkg::*;

  typedef struct packed {
    logic [1:0][6:0]  addr;
    logic [1:0][15:0] status;
    logic [1:0][15:0] inten;
    logic             vbus_q;
    logic             id_q;
    logic             pin_seen;
    logic [1:0]       accept;
    logic [15:0]      cpu_rdata;
    logic [15:0]      hpi_rdata;
  } uda_state_type;

  uda_state_type st_r;
  uda_state_type st_nxt;

  function automatic uda_rsel_type reg_of(input logic [15:0] a,
                                          input int unsigned e);
    logic [15:0] base_a;
    logic [15:0] base_s;
    logic [15:0] base_i;
    base_a = (e == 0) ? OFS_ADDR_1 : OFS_ADDR_2;
    base_s = (e == 0) ? OFS_STAT_1 : OFS_STAT_2;
    base_i = (e == 0) ? OFS_INTEN_1 : OFS_INTEN_2;
    if (a == base_a)
      return RS_ADDR;
    else if (a == base_s)
      return RS_STAT;
    else if (a == base_i)
      return RS_INTEN;
    return RS_NONE;
  endfunction : reg_of

  function automatic logic [15:0] eng_mask(input int unsigned e);
    return (e == 0) ? MASK_ENG_1 : MASK_ENG_2;
  endfunction : eng_mask

  // address register is write only, so it reads back zero
  function automatic logic [15:0] read_word(input uda_rsel_type s,
                                            input logic [15:0] stat,
                                            input logic [15:0] ien);
    unique case (s)
      RS_STAT:  return stat;
      RS_INTEN: return ien;
      RS_ADDR:  return 16'h0000;
      RS_NONE:  return 16'h0000;
    endcase
  endfunction : read_word

  always_comb
  begin
    logic [15:0] clr;
    logic [15:0] ev;
    logic        vbus_edge;
    logic        id_edge;
    clr       = 16'h0000;
    ev        = 16'h0000;
    vbus_edge = 1'b0;
    id_edge   = 1'b0;
    st_nxt    = st_r;
    if (i_clk_en)
    begin
      // pin levels are compared only once a first sample exists, so
      // leaving reset never fakes an edge
      vbus_edge       = st_r.pin_seen && (i_vbus_valid != st_r.vbus_q);
      id_edge         = st_r.pin_seen && (i_otg_id != st_r.id_q);
      st_nxt.vbus_q   = i_vbus_valid;
      st_nxt.id_q     = i_otg_id;
      st_nxt.pin_seen = 1'b1;
      st_nxt.cpu_rdata = 16'h0000;
      st_nxt.hpi_rdata = 16'h0000;
      for (int unsigned e = 0; e < ENG_COUNT; e++)
      begin
        clr = 16'h0000;
        // processor wins a same-cycle write to address or enable
        if (i_hpi_wr && reg_of(i_hpi_addr, e) == RS_ADDR)
          st_nxt.addr[e] = i_hpi_wdata[6:0];
        if (i_cpu_wr && reg_of(i_cpu_addr, e) == RS_ADDR)
          st_nxt.addr[e] = i_cpu_wdata[6:0];
        if (i_hpi_wr && reg_of(i_hpi_addr, e) == RS_INTEN)
          st_nxt.inten[e] = i_hpi_wdata & eng_mask(e);
        if (i_cpu_wr && reg_of(i_cpu_addr, e) == RS_INTEN)
          st_nxt.inten[e] = i_cpu_wdata & eng_mask(e);
        if (i_hpi_wr && reg_of(i_hpi_addr, e) == RS_STAT)
          clr = clr | i_hpi_wdata;
        if (i_cpu_wr && reg_of(i_cpu_addr, e) == RS_STAT)
          clr = clr | i_cpu_wdata;
        ev        = 16'h0000;
        ev[7:0]   = i_ep_done[e]
                    | (i_ep_nak[e] & i_nak_int_en[e]);
        ev[BIT_BUS_RESET] = i_bus_reset[e];
        ev[BIT_SOF_EOP]   = i_sof_eop[e];
        ev[BIT_ID]        = (e == 0) && id_edge;
        ev[BIT_VBUS]      = (e == 0) && vbus_edge;
        // set is applied after the clear so a same-cycle clear never drops an event
        st_nxt.status[e] = ((st_r.status[e] & ~clr)
                            | (ev & st_r.inten[e]))
                           & eng_mask(e);
        // match uses the address held before any same-cycle write
        st_nxt.accept[e] = i_pkt_valid[e]
                           && (i_pkt_addr[e] == st_r.addr[e]);
        if (i_cpu_rd && reg_of(i_cpu_addr, e) != RS_NONE)
          st_nxt.cpu_rdata = read_word(reg_of(i_cpu_addr, e),
                                       st_r.status[e], st_r.inten[e]);
        if (i_hpi_rd && reg_of(i_hpi_addr, e) != RS_NONE)
          st_nxt.hpi_rdata = read_word(reg_of(i_hpi_addr, e),
                                       st_r.status[e], st_r.inten[e]);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r           <= '0;
      st_r.addr[0]   <= RST_DEV_ADDR;
      st_r.addr[1]   <= RST_DEV_ADDR;
      st_r.status[0] <= RST_STATUS;
      st_r.status[1] <= RST_STATUS;
      st_r.inten[0]  <= RST_INTEN;
      st_r.inten[1]  <= RST_INTEN;
    end
    else
      st_r <= st_nxt;
  end

  assign o_cpu_rdata  = st_r.cpu_rdata;
  assign o_hpi_rdata  = st_r.hpi_rdata;
  assign o_pkt_accept = st_r.accept;

  a_accept_hit: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_pkt_valid[0] && i_pkt_addr[0] == st_r.addr[0]
    |=> o_pkt_accept[0])
    else $error("matching packet not accepted");

  a_accept_miss: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_pkt_addr[1] != st_r.addr[1]
    |=> !o_pkt_accept[1])
    else $error("packet to another address accepted");

  a_w1c_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_cpu_wr && i_cpu_addr == OFS_STAT_1 && i_cpu_wdata[0]
    && !i_ep_done[0][0] && !i_ep_nak[0][0]
    |=> !st_r.status[0][0])
    else $error("write one did not clear flag");

  a_w0_keeps: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    st_r.status[0][3] && i_cpu_wr && i_cpu_addr == OFS_STAT_1
    && !i_cpu_wdata[3] && !i_hpi_wr
    |=> st_r.status[0][3])
    else $error("write zero cleared a flag");

  a_set_wins: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_bus_reset[0] && st_r.inten[0][BIT_BUS_RESET]
    ##0 (i_cpu_wr && i_cpu_addr == OFS_STAT_1)
    |=> st_r.status[0][BIT_BUS_RESET])
    else $error("bus reset event lost");

  a_sof_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_sof_eop[1] && st_r.inten[1][BIT_SOF_EOP]
    |=> st_r.status[1][BIT_SOF_EOP])
    else $error("frame marker flag not set");

  a_vbus_edge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && st_r.pin_seen && i_vbus_valid != st_r.vbus_q
    && st_r.inten[0][BIT_VBUS]
    |=> st_r.status[0][BIT_VBUS])
    else $error("supply crossing flag not set");

  a_id_edge: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && st_r.pin_seen && $changed(i_otg_id)
    && $past(i_clk_en) && st_r.inten[0][BIT_ID]
    |=> st_r.status[0][BIT_ID])
    else $error("id edge flag not set");

  a_dev2_rsvd: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    st_r.status[1][15:14] == 2'b00)
    else $error("second engine shows otg flags");

  a_gate_off: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && !st_r.inten[0][BIT_BUS_RESET]
    && !st_r.status[0][BIT_BUS_RESET]
    |=> !st_r.status[0][BIT_BUS_RESET])
    else $error("disabled event set its flag");

  a_ep_done: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_ep_done[1][7] && st_r.inten[1][7]
    |=> st_r.status[1][7] ##1 (st_r.status[1][7] || $past(i_cpu_wr)
    || $past(i_hpi_wr)))
    else $error("endpoint flag not set or dropped");

  a_hpi_read: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_clk_en && i_hpi_rd && i_hpi_addr == OFS_STAT_2
    |=> o_hpi_rdata == $past(st_r.status[1]))
    else $error("port read of status wrong");
endmodule : uda_regs
`default_nettype wire
